// ===== hw/asr_rx.sv
/*
 * Asynchronous serial receiver: start-bit qualification, mid-bit
 * majority voting, double-buffered holding register and status flags.
 * Assumes reads of the status and data words arrive as one-cycle pulses
 * from logic on core_clk_i; the receive pin is asynchronous.
 */
module asr_rx (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	input  wire logic       clk_en_i,
	// receive pin
	input  wire logic       rx_line_i,
	// control
	input  wire logic       rx_on_ctl_i,
	input  wire logic       nine_bit_i,
	input  wire logic       parity_on_i,
	input  wire logic       parity_odd_i,
	input  wire logic       rx_irq_en_i,
	// processor read strobes
	input  wire logic       status_rd_i,
	input  wire logic       data_rd_i,
	// received data
	output logic      [7:0] rx_holding_buffer_o,
	output logic            ninth_rx_bit_o,
	// status
	output logic            rx_full_flag_o,
	output logic            overrun_flag_o,
	output logic            noise_flag_o,
	output logic            framing_err_flag_o,
	output logic            parity_err_flag_o,
	output logic            rx_active_flag_o,
	output logic            rx_irq_o
);

	asr_smp_if smp ();

	asr_pkg::asr_rx_state_t r_reg;
	asr_pkg::asr_rx_state_t r_next;

	logic       adv;
	logic       line;
	logic       fall;
	logic       vote;
	logic       noisy;
	logic       frame_done;
	logic       parity_bad;
	logic [3:0] last_idx;
	logic [4:0] ph_inc;

	// ------------------------------------------------------------------
	// oversample tick and line synchroniser
	// ------------------------------------------------------------------
	asr_tick u_tick (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.clk_en_i   (clk_en_i),
		.rx_line_i  (rx_line_i),
		.smp        (smp.src)
	);

	// derived sampling terms
	assign adv      = smp.tick & clk_en_i;
	assign line     = smp.line;
	assign fall     = r_reg.hist[0] & ~line;
	assign vote     = asr_pkg::maj3(r_reg.s_a, r_reg.s_b, line);
	assign last_idx = nine_bit_i ? asr_pkg::IDX_STOP9
		: asr_pkg::IDX_STOP8;
	assign ph_inc   = r_reg.phase + 5'h01;
	// the parity bit sits in the last data position, so the sum of all
	// data bits including it must be even (or odd)
	assign parity_bad = (nine_bit_i ? ^r_reg.shf : ^r_reg.shf[7:0])
		^ parity_odd_i;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		r_next     = r_reg;
		frame_done = 1'b0;
		noisy      = 1'b0;

		// status word read arms, data word read clears; placed first so
		// that a frame ending in the same cycle wins over the clear
		if (clk_en_i && status_rd_i) begin
			r_next.armed = 1'b1;
		end
		if (clk_en_i && data_rd_i && r_reg.armed) begin
			r_next.armed = 1'b0;
			r_next.full  = 1'b0;
			r_next.ovr   = 1'b0;
			r_next.nf    = 1'b0;
			r_next.fe    = 1'b0;
			r_next.pf    = 1'b0;
		end

		if (!rx_on_ctl_i) begin
			// disabled: bit processor held at its initial state
			r_next.mode    = asr_pkg::ASR_SEARCH;
			r_next.rx_active_flag     = 1'b0;
			r_next.wnoise  = 1'b0;
			r_next.hist    = '0;
			r_next.phase   = '0;
			r_next.bit_idx = '0;
		end else if (adv) begin
			r_next.hist = {r_reg.hist[1:0], line};
			case (r_reg.mode)
				asr_pkg::ASR_SEARCH: begin
					// searching begins as soon as the receiver is on
					if (fall && r_reg.hist == asr_pkg::HIST_HIGH) begin
						r_next.mode  = asr_pkg::ASR_START;
						r_next.phase = asr_pkg::PH_1;
						r_next.rx_active_flag   = 1'b1;
					end else if (fall) begin
						r_next.wnoise = 1'b1;
					end
				end
				asr_pkg::ASR_START: begin
					// no resynchronising before the start is qualified;
					// r_reg.phase names the previous tick, ph_inc this one
					r_next.phase = ph_inc;
					if (ph_inc == asr_pkg::PH_3) begin
						r_next.s_a = line;
					end else if (ph_inc == asr_pkg::PH_5) begin
						r_next.s_b = line;
						if (r_reg.s_a && line) begin
							r_next.wnoise = 1'b1;
							r_next.rx_active_flag    = 1'b0;
							r_next.mode   = asr_pkg::ASR_SEARCH;
						end
					end else if (ph_inc == asr_pkg::PH_7) begin
						if (vote) begin
							r_next.wnoise = 1'b1;
							r_next.rx_active_flag    = 1'b0;
							r_next.mode   = asr_pkg::ASR_SEARCH;
						end else begin
							if (asr_pkg::differ3(r_reg.s_a, r_reg.s_b,
								line)) begin
								r_next.wnoise = 1'b1;
							end
							r_next.mode    = asr_pkg::ASR_BITS;
							r_next.bit_idx = asr_pkg::IDX_START;
						end
					end
				end
				asr_pkg::ASR_BITS: begin
					// resync on any falling edge or after phase 16
					if (fall || r_reg.phase == asr_pkg::PH_16) begin
						r_next.phase = asr_pkg::PH_1;
						// an edge past the vote opens the next bit time
						if (r_reg.phase >= asr_pkg::PH_10) begin
							r_next.bit_idx = r_reg.bit_idx + 4'h1;
						end
					end else begin
						r_next.phase = ph_inc;
					end
					// samples at phases 8, 9, 10 for every bit
					if (r_next.phase == asr_pkg::PH_8) begin
						r_next.s_a = line;
					end else if (r_next.phase == asr_pkg::PH_9) begin
						r_next.s_b = line;
					end else if (r_next.phase == asr_pkg::PH_10) begin
						noisy = asr_pkg::differ3(r_reg.s_a, r_reg.s_b,
							line);
						if (noisy) begin
							r_next.wnoise = 1'b1;
						end
						// data lsb first into the hidden shifter
						if (r_reg.bit_idx >= asr_pkg::IDX_D0 &&
							r_reg.bit_idx <= asr_pkg::IDX_D7) begin
							r_next.shf[r_reg.bit_idx - asr_pkg::IDX_D0] =
								vote;
						end
						if (nine_bit_i &&
							r_reg.bit_idx == asr_pkg::IDX_NINTH) begin
							r_next.shf[8] = vote;
						end
						if (r_reg.bit_idx == last_idx) begin
							frame_done = 1'b1;
						end
					end
					if (frame_done) begin
						// sync released at the stop bit's phase-10 vote
						r_next.mode    = asr_pkg::ASR_SEARCH;
						r_next.rx_active_flag     = 1'b0;
						r_next.wnoise  = 1'b0;
						r_next.bit_idx = '0;
						// every flag of the frame lands here at once
						if (r_reg.full) begin
							r_next.ovr = 1'b1;
						end else begin
							r_next.full  = 1'b1;
							r_next.hold  = r_reg.shf[7:0];
							r_next.hold9 = nine_bit_i ? r_reg.shf[8]
								: r_reg.hold9;
							r_next.nf    = r_reg.wnoise | noisy;
							r_next.fe    = ~vote;
							r_next.pf    = parity_on_i & parity_bad;
							r_next.armed = 1'b0;
						end
					end
				end
				default: begin
					r_next.mode = asr_pkg::ASR_SEARCH;
				end
			endcase
		end

		// request while data waits and the enable is set
		r_next.irq = r_next.full & rx_irq_en_i;
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg <= asr_pkg::RX_RESET;
		end else if (clk_en_i) begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign rx_holding_buffer_o = r_reg.hold;
	assign ninth_rx_bit_o      = r_reg.hold9;
	assign rx_full_flag_o      = r_reg.full;
	assign overrun_flag_o      = r_reg.ovr;
	assign noise_flag_o        = r_reg.nf;
	assign framing_err_flag_o  = r_reg.fe;
	assign parity_err_flag_o   = r_reg.pf;
	assign rx_active_flag_o    = r_reg.rx_active_flag;
	assign rx_irq_o            = r_reg.irq;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_start_edge;
		adv && rx_on_ctl_i && r_reg.mode == asr_pkg::ASR_SEARCH &&
			fall && r_reg.hist == asr_pkg::HIST_HIGH;
	endsequence

	sequence s_frame_new;
		frame_done && rx_on_ctl_i && !r_reg.full;
	endsequence

	sequence s_frame_over;
		frame_done && rx_on_ctl_i && r_reg.full;
	endsequence

	a_start_sets_active: assert property (
		s_start_edge |=> r_reg.rx_active_flag && r_reg.phase == asr_pkg::PH_1)
		else $error("start edge did not set active flag");

	a_early_reject: assert property (
		adv && rx_on_ctl_i && r_reg.mode == asr_pkg::ASR_START &&
		ph_inc == asr_pkg::PH_5 && r_reg.s_a && line
		|=> !r_reg.rx_active_flag && r_reg.wnoise &&
			r_reg.mode == asr_pkg::ASR_SEARCH)
		else $error("high phases 3 and 5 not rejected");

	a_phase_wrap: assert property (
		adv && rx_on_ctl_i && r_reg.mode == asr_pkg::ASR_BITS &&
		r_reg.phase == asr_pkg::PH_16 |=> r_reg.phase == asr_pkg::PH_1)
		else $error("phase did not restart after 16");

	a_frame_fills: assert property (
		s_frame_new |=> r_reg.full && !r_reg.ovr ##1 1'b1)
		else $error("completed frame did not set full");

	a_overrun_keeps: assert property (
		s_frame_over |=> r_reg.ovr && $stable(r_reg.hold) &&
			$stable(r_reg.nf))
		else $error("overrun changed held data or flags");

	a_noise_with_full: assert property (
		$rose(r_reg.nf) |-> $rose(r_reg.full))
		else $error("noise flag set without full");

	a_framing_err: assert property (
		s_frame_new and (!vote) |=> r_reg.fe)
		else $error("zero stop bit did not flag framing");

	a_disabled_idle: assert property (
		clk_en_i && !rx_on_ctl_i
		|=> (r_reg.mode == asr_pkg::ASR_SEARCH && !r_reg.rx_active_flag) [*2])
		else $error("disabled receiver not held idle");

	a_read_clears: assert property (
		clk_en_i && r_reg.armed && data_rd_i && !frame_done
		|=> !r_reg.full && !r_reg.ovr && !r_reg.fe)
		else $error("armed data read did not clear flags");

	a_irq_follows: assert property (
		clk_en_i && r_reg.full && rx_irq_en_i && !data_rd_i
		|=> rx_irq_o)
		else $error("full with enable gave no interrupt");

endmodule : asr_rx

// ===== hw/asr_pkg.sv
/*
 * Constants, state types and shared helpers for the asynchronous serial
 * receiver. Assumes a single 50 MHz core clock and a fixed line rate.
 */
// Functional notes
// - sample line at sixteen ticks per bit
// - enabling receiver starts start-bit search
// - low after three highs starts bit, sets active
// - other low in search flags working noise
// - phases 3 and 5 high reject start
// - two of phases 3,5,7 high reject
// - phase restarts on falling edge or phase 16
// - hold sync through stop, then search again
// - every bit voted from phases 8,9,10
// - disagreeing samples set working noise
// - working noise sets noise flag with full
// - shifter and holding buffer double-buffer data
// - disabled receiver held initialised
// - start, eight data lsb first, ninth optional
// - zero stop bit sets framing error
// - full blocks transfer, flags overrun, keeps data
// - frame sets full or overrun, never both
// - interrupt while full and enabled
// - all frame flags set in one cycle
// - status read arms, data read clears flags
// - frame length select picks 10 or 11 bits
// - parity enable makes last data bit parity
package asr_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int         CLK_HZ    = 50_000_000;
	localparam int         BAUD_HZ   = 115200;
	localparam int         OVS       = 16;
	localparam int         TICK_DIV  = CLK_HZ / (BAUD_HZ * OVS);
	localparam logic [8:0] TICK_LAST = 9'(TICK_DIV - 1);

	// ------------------------------------------------------------------
	// sample phases and bit positions
	// ------------------------------------------------------------------
	localparam logic [4:0] PH_1  = 5'h01;
	localparam logic [4:0] PH_3  = 5'h03;
	localparam logic [4:0] PH_5  = 5'h05;
	localparam logic [4:0] PH_7  = 5'h07;
	localparam logic [4:0] PH_8  = 5'h08;
	localparam logic [4:0] PH_9  = 5'h09;
	localparam logic [4:0] PH_10 = 5'h0A;
	localparam logic [4:0] PH_16 = 5'h10;
	localparam logic [3:0] IDX_START = 4'h0;
	localparam logic [3:0] IDX_D0    = 4'h1;
	localparam logic [3:0] IDX_D7    = 4'h8;
	localparam logic [3:0] IDX_NINTH = 4'h9;
	localparam logic [3:0] IDX_STOP8 = 4'h9;
	localparam logic [3:0] IDX_STOP9 = 4'hA;
	localparam logic [2:0] HIST_HIGH = 3'h7;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ASR_SEARCH,
		ASR_START,
		ASR_BITS
	} asr_mode_t;

	typedef struct packed {
		asr_mode_t  mode;
		logic [4:0] phase;
		logic [3:0] bit_idx;
		logic [2:0] hist;
		logic       s_a;
		logic       s_b;
		logic       rx_active_flag;
		logic       wnoise;
		logic [8:0] shf;
		logic [7:0] hold;
		logic       hold9;
		logic       full;
		logic       ovr;
		logic       nf;
		logic       fe;
		logic       pf;
		logic       armed;
		logic       irq;
	} asr_rx_state_t;

	localparam asr_rx_state_t RX_RESET = '0;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic maj3(input logic a, input logic b,
		input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction : maj3

	function automatic logic differ3(input logic a, input logic b,
		input logic c);
		differ3 = (a != b) || (b != c);
	endfunction : differ3

endpackage : asr_pkg

// ===== hw/asr_smp_if.sv
/*
 * Carrier between the tick/synchroniser module and the receiver core.
 * Assumes both ends run on the same core clock.
 */
interface asr_smp_if;
	logic tick;   // one-cycle oversample pulse
	logic line;   // synchronised receive line

	// ------------------------------------------------------------------
	// modports
	// ------------------------------------------------------------------
	modport src (output tick, output line);
	modport dst (input tick, input line);
endinterface : asr_smp_if

// ===== hw/asr_tick.sv
/*
 * Oversample tick generator and receive-line synchroniser.
 * Assumes the receive pin is asynchronous to core_clk_i.
 */
module asr_tick (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_en_i,
	// receive pin
	input  wire logic rx_line_i,
	// to the receiver core
	asr_smp_if.src    smp
);

	typedef struct packed {
		logic [8:0] cnt;
		logic [1:0] sync;
		logic       tick;
	} asr_tick_state_t;

	asr_tick_state_t r_reg;
	asr_tick_state_t r_next;

	// ------------------------------------------------------------------
	// divider and two-stage synchroniser
	// ------------------------------------------------------------------
	// sync[0] feeds only sync[1]; nothing else looks at the first stage
	always_comb begin
		r_next      = r_reg;
		r_next.sync = {r_reg.sync[0], rx_line_i};
		r_next.tick = 1'b0;
		if (r_reg.cnt == asr_pkg::TICK_LAST) begin
			r_next.cnt  = '0;
			r_next.tick = 1'b1;   // sixteen per bit time
		end else begin
			r_next.cnt = r_reg.cnt + 9'h001;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg <= '0;
		end else if (clk_en_i) begin
			r_reg <= r_next;
		end
	end

	assign smp.tick = r_reg.tick;
	assign smp.line = r_reg.sync[1];

endmodule : asr_tick

// ===== verification/asr_tx_model.sv
/*
 * Far-end transmitter model that drives the receive line.
 * Assumes the receiver's tick divider and sixteen ticks per bit.
 */
module asr_tx_model (
	// clock
	input  wire logic core_clk_i,
	// serial line
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// line timing
	// ------------------------------------------------------------------
	localparam int TK = asr_pkg::TICK_DIV;

	// the line idles at mark
	initial begin
		line_o = 1'b1;
	end

	// hold one level for n ticks, changing just after an edge
	task automatic hold(input logic v, input int n);
		@(posedge core_clk_i);
		#2 line_o = v;
		repeat (n * TK - 1) @(posedge core_clk_i);
	endtask : hold

	// one frame; g picks a space bit that gets a one-tick mark glitch
	task automatic send(input logic [8:0] d, input logic nine,
		input logic stop, input int g);
		int i;
		hold(1'b0, 16);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			if (i == g) begin
				// glitch sits on the tenth phase so its fall follows the vote
				hold(1'b0, 9);
				hold(1'b1, 1);
				hold(1'b0, 6);
			end else begin
				hold(d[i], 16);
			end
		end
		hold(stop, 16);
		hold(1'b1, 16); // mark gap refills the receiver's history
	endtask : send

	// short space that looks like a start edge but is noise
	task automatic blip(input int w);
		hold(1'b0, w);
		hold(1'b1, 32);
	endtask : blip

endmodule : asr_tx_model

// ===== verification/asr_rx_tb_top.sv
/*
 * Self-checking bench for the serial receiver with a far-end model.
 * Assumes the fixed line rate, so each frame takes about 0.1 ms.
 */
module asr_rx_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int TK = asr_pkg::TICK_DIV;
	logic       clk;
	logic       rst;
	logic       rx_on;
	logic       nine;
	logic       par_on;
	logic       par_odd;
	logic       irq_en;
	logic       st_rd;
	logic       dt_rd;
	logic       line;
	logic [7:0] hold_q;
	logic       ninth;
	logic       full;
	logic       ovr;
	logic       nf;
	logic       fe;
	logic       pf;
	logic       rx_active_flag;
	logic       irq;
	logic [4:0] flags;
	int         bad_count;
	int         checks_done;

	assign flags = {full, ovr, nf, fe, pf};

	// ------------------------------------------------------------------
	// design and far end
	// ------------------------------------------------------------------
	asr_rx u_dut (
		.core_clk_i          (clk),
		.reset_i             (rst),
		.clk_en_i            (1'b1),
		.rx_line_i           (line),
		.rx_on_ctl_i         (rx_on),
		.nine_bit_i          (nine),
		.parity_on_i         (par_on),
		.parity_odd_i        (par_odd),
		.rx_irq_en_i         (irq_en),
		.status_rd_i         (st_rd),
		.data_rd_i           (dt_rd),
		.rx_holding_buffer_o (hold_q),
		.ninth_rx_bit_o      (ninth),
		.rx_full_flag_o      (full),
		.overrun_flag_o      (ovr),
		.noise_flag_o        (nf),
		.framing_err_flag_o  (fe),
		.parity_err_flag_o   (pf),
		.rx_active_flag_o    (rx_active_flag),
		.rx_irq_o            (irq)
	);

	asr_tx_model u_tx (
		.core_clk_i (clk),
		.line_o     (line)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// advance n edges and land where outputs are settled
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step

	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	// status order: full, overrun, noise, framing, parity
	task automatic check_st(input logic [4:0] want);
		check({4'h0, flags}, {4'h0, want});
	endtask : check_st

	task automatic frame(input logic [8:0] d, input logic n9,
		input logic stop, input int g);
		u_tx.send(d, n9, stop, g);
		step(1);
	endtask : frame

	// status read arms, data read clears on the following edge
	task automatic clear_flags();
		st_rd = 1'b1;
		step(1);
		st_rd = 1'b0;
		dt_rd = 1'b1;
		step(1);
		dt_rd = 1'b0;
		check_st(5'h00);
		step(1);
		check({8'h0, irq}, 9'h000);
	endtask : clear_flags

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_basic();
		frame(9'h0A5, 1'b0, 1'b1, -1);
		check({1'b0, hold_q}, 9'h0A5);
		check_st(5'h10);
		check({7'h0, rx_active_flag, irq}, 9'h001);
		$display("test basic done");
	endtask : t_basic

	// bad stop while full: only overrun, old byte kept
	task automatic t_overrun();
		frame(9'h05A, 1'b0, 1'b0, -1);
		check({1'b0, hold_q}, 9'h0A5);
		check_st(5'h18);
		dt_rd = 1'b1;
		step(1);
		dt_rd = 1'b0;
		step(1);
		check_st(5'h18);
		clear_flags();
		$display("test overrun done");
	endtask : t_overrun

	task automatic t_disable();
		rx_on = 1'b0;
		frame(9'h011, 1'b0, 1'b1, -1);
		check({3'h0, rx_active_flag, flags}, 9'h000);
		rx_on = 1'b1;
		step(4 * TK);
		$display("test disable done");
	endtask : t_disable

	// zero stop bit on an empty buffer: data loads with framing error
	task automatic t_framing();
		frame(9'h0F0, 1'b0, 1'b0, -1);
		check({1'b0, hold_q}, 9'h0F0);
		check_st(5'h12);
		clear_flags();
		$display("test framing done");
	endtask : t_framing

	// one disagreeing mid-bit sample: vote holds, noise reported
	task automatic t_noise();
		frame(9'h000, 1'b0, 1'b1, 3);
		check({1'b0, hold_q}, 9'h000);
		check_st(5'h14);
		clear_flags();
		$display("test noise done");
	endtask : t_noise

	// a two-tick space fails at phase 5, a four-tick space at phase 7
	task automatic t_start_rej();
		int w;
		for (w = 2; w <= 4; w += 2) begin
			fork
				u_tx.blip(w);
			join_none
			step(TK * 3 / 2);
			check({8'h0, rx_active_flag}, 9'h001);
			step(TK * 7);
			check({3'h0, rx_active_flag, flags}, 9'h000);
			wait fork;
			step(1);
		end
		$display("test start reject done");
	endtask : t_start_rej

	// odd parity in bit seven; the earlier reject left working noise
	task automatic t_par8();
		par_on = 1'b1;
		par_odd = 1'b1;
		frame(9'h083, 1'b0, 1'b1, -1);
		check({1'b0, hold_q}, 9'h083);
		check_st(5'h14);
		clear_flags();
		$display("test parity8 done");
	endtask : t_par8

	// even parity in the ninth bit, sent wrong, interrupt masked
	task automatic t_par9();
		nine = 1'b1;
		par_odd = 1'b0;
		irq_en = 1'b0;
		frame(9'h13C, 1'b1, 1'b1, -1);
		check({ninth, hold_q}, 9'h13C);
		check_st(5'h11);
		check({8'h0, irq}, 9'h000);
		clear_flags();
		$display("test parity9 done");
	endtask : t_par9

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		rx_on = 1'b1;
		nine = 1'b0;
		par_on = 1'b0;
		par_odd = 1'b0;
		irq_en = 1'b1;
		st_rd = 1'b0;
		dt_rd = 1'b0;
		bad_count = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		#2 rst = 1'b0;
		step(4 * TK);
		t_basic();
		t_overrun();
		t_disable();
		t_framing();
		t_noise();
		t_start_rej();
		t_par8();
		t_par9();
		test_done();
	end

	// seven frames of about 0.1 ms each, with ample margin
	initial begin
		#1_500_000;
		bad_count++;
		test_done();
	end

endmodule : asr_rx_tb_top
